// file: logic/amnu_lmfc.sv
// Local multiframe or extended multiblock counter, realigned by a captured timing event.
`timescale 1ns/1ps
module amnu_lmfc #(
	parameter int unsigned CW = 8
) (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic [CW-1:0] period_i,
	input wire logic align_i,
	// Outputs
	output logic edge_o,
	output logic realign_o
);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] last;
	logic edge_q;
	logic edge_d;
	logic realign_q;
	logic realign_d;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb begin
		last = CW'(period_i - CW'(1));
		if (align_i || cnt_q == last) begin
			cnt_d = '0;
		end else begin
			cnt_d = CW'(cnt_q + CW'(1));
		end
		edge_d = (cnt_d == '0);
		realign_d = align_i && (cnt_q != last);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			edge_q <= 1'b0;
			realign_q <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			edge_q <= edge_d;
			realign_q <= realign_d;
		end
	end

	assign edge_o = edge_q;
	assign realign_o = realign_q;

endmodule // amnu_lmfc

// file: logic/amnu_osc_bank.sv
// Bank of phase accumulators for one channel with a selected, phase-offset output.
`timescale 1ns/1ps
module amnu_osc_bank #(
	parameter int unsigned N = 4,
	parameter int unsigned W = 32,
	parameter int unsigned SW = 2
) (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic sync_i,
	input wire logic run_i,
	input wire logic [SW-1:0] sel_i,
	// Words, flattened by index
	input wire logic [N*W-1:0] freq_i,
	input wire logic [N*W-1:0] phase_i,
	// Outputs
	output logic [N*W-1:0] words_o,
	output logic [W-1:0] osc_o
);

	logic [W-1:0] acc_q [N];
	logic [W-1:0] acc_d [N];
	logic [W-1:0] word_q [N];
	logic [W-1:0] word_d [N];
	logic [W-1:0] osc_d;
	logic [W-1:0] osc_q;

	// ------------------------------------------------------------
	// Accumulators
	// ------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_acc
		always_comb begin
			acc_d[g] = acc_q[g];
			if (sync_i) begin
				acc_d[g] = '0;
			end else if (run_i) begin
				acc_d[g] = acc_q[g] + freq_i[g*W +: W];
			end
			word_d[g] = acc_q[g] + phase_i[g*W +: W];
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				acc_q[g] <= '0;
				word_q[g] <= '0;
			end else if (ce_i) begin
				acc_q[g] <= acc_d[g];
				word_q[g] <= word_d[g];
			end
		end
		assign words_o[g*W +: W] = word_q[g];
	end

	// ------------------------------------------------------------
	// Selected output
	// ------------------------------------------------------------
	always_comb begin
		osc_d = word_d[sel_i];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_q <= '0;
		end else if (ce_i) begin
			osc_q <= osc_d;
		end
	end

	assign osc_o = osc_q;

endmodule // amnu_osc_bank

// file: logic/amnu_pkg.sv
// Shared constants for the alarm monitor: register map, field layout, reset values and link states.
package amnu_pkg;

	// ------------------------------------------------------------
	// Bus and word sizes
	// ------------------------------------------------------------
	localparam int unsigned AW = 8;
	localparam int unsigned DW = 32;
	localparam int unsigned OSC_N = 4;
	localparam int unsigned OSC_W = 32;
	localparam int unsigned SEL_W = 2;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned ILAS_W = 4;
	localparam int unsigned ALM_N = 6;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [AW-1:0] ADR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADR_MASK = 8'h04;
	localparam logic [AW-1:0] ADR_STATUS = 8'h08;
	localparam logic [AW-1:0] ADR_SUMMARY = 8'h0c;
	localparam logic [AW-1:0] ADR_TIMING = 8'h10;
	localparam logic [AW-1:0] ADR_FREQ_A = 8'h40;
	localparam logic [AW-1:0] ADR_FREQ_B = 8'h50;
	localparam logic [AW-1:0] ADR_PHASE_A = 8'h60;
	localparam logic [AW-1:0] ADR_PHASE_B = 8'h70;

	// ------------------------------------------------------------
	// Alarm bit positions in the alarm flag word
	// ------------------------------------------------------------
	localparam int unsigned ALM_FIFO = 0;
	localparam int unsigned ALM_PLL = 1;
	localparam int unsigned ALM_LINK = 2;
	localparam int unsigned ALM_SYSREF = 3;
	localparam int unsigned ALM_OSC = 4;
	localparam int unsigned ALM_CLK = 5;

	// ------------------------------------------------------------
	// Control, timing and summary fields
	// ------------------------------------------------------------
	localparam int unsigned CTRL_LINK_EN = 0;
	localparam int unsigned CTRL_PD_A = 1;
	localparam int unsigned CTRL_PD_B = 2;
	localparam int unsigned CTRL_PIN_ALARM = 3;
	localparam int unsigned CTRL_SYNC_ILAS = 4;
	localparam int unsigned CTRL_ENC_64 = 5;
	localparam int unsigned CTRL_SUBCLASS0 = 6;
	localparam int unsigned CTRL_SRC_REG = 7;
	localparam int unsigned CTRL_CHOICE_A = 8;
	localparam int unsigned CTRL_CHOICE_B = 10;
	localparam int unsigned TIM_MF = 0;
	localparam int unsigned TIM_EMB = 8;
	localparam int unsigned TIM_ILAS = 16;
	localparam int unsigned SUM_ALARM = 0;
	localparam int unsigned SUM_OSC_VALID = 1;
	localparam int unsigned SUM_STATE = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
	localparam logic [ALM_N-1:0] MASK_RST = 6'h00;
	localparam logic [DW-1:0] TIMING_RST = 32'h0004_2020;

	typedef enum logic [1:0] {LNK_OFF, LNK_CGS, LNK_ILAS, LNK_DATA} amnu_link_t;

endpackage

// file: logic/amnu_top.sv
// Alarm monitor with oscillator upset check, link state tracking and a Wishbone register file.
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module amnu_top (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [amnu_pkg::AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [amnu_pkg::DW-1:0] wb_dat_i,
	output logic [amnu_pkg::DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Alarm sources
	input wire logic ser_fifo_err_i,
	input wire logic ser_pll_locked_i,
	input wire logic clk_upset_i,
	input wire logic cal_busy_i,
	// Timing and link
	input wire logic sysref_i,
	input wire logic sync_n_i,
	input wire logic [amnu_pkg::SEL_W-1:0] chan_a_osc_select_pins_i,
	input wire logic [amnu_pkg::SEL_W-1:0] chan_b_osc_select_pins_i,
	// Status and link control
	output logic alarm_o,
	output logic cal_state_pin_o,
	output logic link_rst_o,
	output logic ser_pd_o,
	output logic link_clk_en_o,
	output logic lmfc_edge_o,
	output logic tx_cgs_o,
	output logic tx_ilas_o,
	output logic tx_data_o,
	// Oscillator outputs
	output logic [amnu_pkg::OSC_W-1:0] chan_a_osc_o,
	output logic [amnu_pkg::OSC_W-1:0] chan_b_osc_o
);

	localparam int unsigned N = amnu_pkg::OSC_N;
	localparam int unsigned W = amnu_pkg::OSC_W;
	localparam int unsigned AN = amnu_pkg::ALM_N;
	localparam int unsigned DW = amnu_pkg::DW;
	localparam int unsigned CW = amnu_pkg::CNT_W;
	localparam int unsigned IW = amnu_pkg::ILAS_W;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [DW-1:0] ctrl_q, ctrl_d, timing_q, timing_d, rd_d, dat_q;
	logic [AN-1:0] mask_q, mask_d, alarm_flag_word_q, alarm_flag_word_d, events, clr;
	logic [W-1:0] fa_q [N];
	logic [W-1:0] fa_d [N];
	logic [W-1:0] fb_q [N];
	logic [W-1:0] fb_d [N];
	logic [W-1:0] pa_q [N];
	logic [W-1:0] pa_d [N];
	logic [W-1:0] pb_q [N];
	logic [W-1:0] pb_d [N];
	logic [N*W-1:0] fa_flat, fb_flat, pa_flat, pb_flat, words_a, words_b;
	logic [DW-1:0] be;
	logic [3:0] region;
	logic [1:0] idx;
	logic ack_q, ack_d, wr, word_wr;
	logic link_en, enc64, pd_a, pd_b;
	logic sysref_q, sysref_cap, lmfc_edge, realign;
	logic [CW-1:0] period;
	amnu_pkg::amnu_link_t state_q, state_d;
	logic [IW-1:0] ilas_cnt_q, ilas_cnt_d, ilas_last;
	logic ilas_start, osc_sync, sync_dly_q, osc_valid_q, osc_valid_d, mismatch;
	logic [amnu_pkg::SEL_W-1:0] sel_a, sel_b;
	logic summary, pin_d, pin_q, cgs_q, ilas_q, data_q;

	assign link_en = ctrl_q[amnu_pkg::CTRL_LINK_EN];
	assign enc64 = ctrl_q[amnu_pkg::CTRL_ENC_64];
	assign pd_a = ctrl_q[amnu_pkg::CTRL_PD_A];
	assign pd_b = ctrl_q[amnu_pkg::CTRL_PD_B];

	// ------------------------------------------------------------
	// Bus decode and register writes
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			be[i*8 +: 8] = {8{wb_sel_i[i]}};
		end
		region = wb_adr_i[amnu_pkg::AW-1:4];
		idx = wb_adr_i[3:2];
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
		ctrl_d = ctrl_q;
		timing_d = timing_q;
		mask_d = mask_q;
		clr = '0;
		word_wr = 1'b0;
		for (int i = 0; i < N; i++) begin
			fa_d[i] = fa_q[i];
			fb_d[i] = fb_q[i];
			pa_d[i] = pa_q[i];
			pb_d[i] = pb_q[i];
		end
		if (wr) begin
			case ({wb_adr_i[amnu_pkg::AW-1:2], 2'b00})
				amnu_pkg::ADR_CTRL: ctrl_d = (ctrl_q & ~be) | (wb_dat_i & be);
				amnu_pkg::ADR_TIMING: timing_d = (timing_q & ~be) | (wb_dat_i & be);
				amnu_pkg::ADR_MASK: mask_d = (mask_q & ~be[AN-1:0]) | (wb_dat_i[AN-1:0] & be[AN-1:0]);
				amnu_pkg::ADR_STATUS: clr = wb_dat_i[AN-1:0] & be[AN-1:0];
				default: begin
					word_wr = 1'b1;
					if (region == amnu_pkg::ADR_FREQ_A[amnu_pkg::AW-1:4]) begin
						fa_d[idx] = (fa_q[idx] & ~be) | (wb_dat_i & be);
					end else if (region == amnu_pkg::ADR_FREQ_B[amnu_pkg::AW-1:4]) begin
						fb_d[idx] = (fb_q[idx] & ~be) | (wb_dat_i & be);
					end else if (region == amnu_pkg::ADR_PHASE_A[amnu_pkg::AW-1:4]) begin
						pa_d[idx] = (pa_q[idx] & ~be) | (wb_dat_i & be);
					end else if (region == amnu_pkg::ADR_PHASE_B[amnu_pkg::AW-1:4]) begin
						pb_d[idx] = (pb_q[idx] & ~be) | (wb_dat_i & be);
					end else begin
						word_wr = 1'b0;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		rd_d = '0;
		case ({wb_adr_i[amnu_pkg::AW-1:2], 2'b00})
			amnu_pkg::ADR_CTRL: rd_d = ctrl_q;
			amnu_pkg::ADR_TIMING: rd_d = timing_q;
			amnu_pkg::ADR_MASK: rd_d[AN-1:0] = mask_q;
			amnu_pkg::ADR_STATUS: rd_d[AN-1:0] = alarm_flag_word_q;
			amnu_pkg::ADR_SUMMARY: begin
				rd_d[amnu_pkg::SUM_ALARM] = summary;
				rd_d[amnu_pkg::SUM_OSC_VALID] = osc_valid_q;
				rd_d[amnu_pkg::SUM_STATE +: 2] = state_q;
			end
			default: begin
				if (region == amnu_pkg::ADR_FREQ_A[amnu_pkg::AW-1:4]) begin
					rd_d = fa_q[idx];
				end else if (region == amnu_pkg::ADR_FREQ_B[amnu_pkg::AW-1:4]) begin
					rd_d = fb_q[idx];
				end else if (region == amnu_pkg::ADR_PHASE_A[amnu_pkg::AW-1:4]) begin
					rd_d = pa_q[idx];
				end else if (region == amnu_pkg::ADR_PHASE_B[amnu_pkg::AW-1:4]) begin
					rd_d = pb_q[idx];
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
			ctrl_q <= amnu_pkg::CTRL_RST;
			timing_q <= amnu_pkg::TIMING_RST;
			mask_q <= amnu_pkg::MASK_RST;
			for (int i = 0; i < N; i++) begin
				fa_q[i] <= '0;
				fb_q[i] <= '0;
				pa_q[i] <= '0;
				pb_q[i] <= '0;
			end
		end else if (ce_i) begin
			ack_q <= ack_d;
			if (ack_d) begin
				dat_q <= rd_d;
			end
			ctrl_q <= ctrl_d;
			timing_q <= timing_d;
			mask_q <= mask_d;
			fa_q <= fa_d;
			fb_q <= fb_d;
			pa_q <= pa_d;
			pb_q <= pb_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ------------------------------------------------------------
	// Frame clock and SYSREF capture
	// ------------------------------------------------------------
	always_comb begin
		sysref_cap = sysref_i && !sysref_q && !ctrl_q[amnu_pkg::CTRL_SUBCLASS0];
		period = enc64 ? timing_q[amnu_pkg::TIM_EMB +: CW] : timing_q[amnu_pkg::TIM_MF +: CW];
	end

	amnu_lmfc #(
		.CW(CW)
	) u_lmfc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.period_i(period),
		.align_i(sysref_cap),
		.edge_o(lmfc_edge),
		.realign_o(realign)
	);

	// ------------------------------------------------------------
	// Link state machine
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ilas_cnt_d = ilas_cnt_q;
		ilas_last = IW'(timing_q[amnu_pkg::TIM_ILAS +: IW] - IW'(1));
		if (!link_en) begin
			state_d = amnu_pkg::LNK_OFF;
		end else begin
			case (state_q)
				amnu_pkg::LNK_OFF: state_d = amnu_pkg::LNK_CGS;
				amnu_pkg::LNK_CGS: begin
					if (enc64) begin
						if (lmfc_edge) begin
							state_d = amnu_pkg::LNK_DATA;
						end
					end else if (sync_n_i && lmfc_edge) begin
						state_d = amnu_pkg::LNK_ILAS;
						ilas_cnt_d = '0;
					end
				end
				amnu_pkg::LNK_ILAS: begin
					if (!sync_n_i) begin
						state_d = amnu_pkg::LNK_CGS;
					end else if (lmfc_edge) begin
						if (ilas_cnt_q == ilas_last) begin
							state_d = amnu_pkg::LNK_DATA;
						end else begin
							ilas_cnt_d = IW'(ilas_cnt_q + IW'(1));
						end
					end
				end
				amnu_pkg::LNK_DATA: begin
					if (!enc64 && !sync_n_i) begin
						state_d = amnu_pkg::LNK_CGS;
					end
				end
				default: state_d = amnu_pkg::LNK_OFF;
			endcase
		end
		ilas_start = (state_d == amnu_pkg::LNK_ILAS) && (state_q != amnu_pkg::LNK_ILAS);
	end

	// ------------------------------------------------------------
	// Oscillator banks and mismatch check
	// ------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_flat
		assign fa_flat[g*W +: W] = fa_q[g];
		assign fb_flat[g*W +: W] = fb_q[g];
		assign pa_flat[g*W +: W] = pa_q[g];
		assign pb_flat[g*W +: W] = pb_q[g];
	end

	always_comb begin
		osc_sync = ctrl_q[amnu_pkg::CTRL_SYNC_ILAS] ? ilas_start : sysref_cap;
		sel_a = ctrl_q[amnu_pkg::CTRL_SRC_REG] ? ctrl_q[amnu_pkg::CTRL_CHOICE_A +: 2] : chan_a_osc_select_pins_i;
		sel_b = ctrl_q[amnu_pkg::CTRL_SRC_REG] ? ctrl_q[amnu_pkg::CTRL_CHOICE_B +: 2] : chan_b_osc_select_pins_i;
		osc_valid_d = osc_valid_q;
		if (!link_en || pd_a || pd_b || word_wr) begin
			osc_valid_d = 1'b0;
		end else if (sync_dly_q) begin
			osc_valid_d = 1'b1;
		end
		mismatch = osc_valid_q && (words_a != words_b);
	end

	amnu_osc_bank #(
		.N(N),
		.W(W),
		.SW(amnu_pkg::SEL_W)
	) u_bank_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sync_i(osc_sync),
		.run_i(!pd_a),
		.sel_i(sel_a),
		.freq_i(fa_flat),
		.phase_i(pa_flat),
		.words_o(words_a),
		.osc_o(chan_a_osc_o)
	);

	amnu_osc_bank #(
		.N(N),
		.W(W),
		.SW(amnu_pkg::SEL_W)
	) u_bank_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sync_i(osc_sync),
		.run_i(!pd_b),
		.sel_i(sel_b),
		.freq_i(fb_flat),
		.phase_i(pb_flat),
		.words_o(words_b),
		.osc_o(chan_b_osc_o)
	);

	// ------------------------------------------------------------
	// Alarm flags, summary and status pin
	// ------------------------------------------------------------
	always_comb begin
		events = '0;
		events[amnu_pkg::ALM_FIFO] = ser_fifo_err_i;
		events[amnu_pkg::ALM_PLL] = !ser_pll_locked_i;
		events[amnu_pkg::ALM_LINK] = link_en && (state_q != amnu_pkg::LNK_DATA);
		events[amnu_pkg::ALM_SYSREF] = realign;
		events[amnu_pkg::ALM_OSC] = mismatch;
		events[amnu_pkg::ALM_CLK] = clk_upset_i;
		alarm_flag_word_d = (alarm_flag_word_q & ~clr) | events;
		summary = |(alarm_flag_word_q & ~mask_q);
		pin_d = ctrl_q[amnu_pkg::CTRL_PIN_ALARM] ? summary : cal_busy_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_flag_word_q <= '0;
			sysref_q <= 1'b0;
			state_q <= amnu_pkg::LNK_OFF;
			ilas_cnt_q <= '0;
			sync_dly_q <= 1'b0;
			osc_valid_q <= 1'b0;
			pin_q <= 1'b0;
			cgs_q <= 1'b0;
			ilas_q <= 1'b0;
			data_q <= 1'b0;
		end else if (ce_i) begin
			alarm_flag_word_q <= alarm_flag_word_d;
			sysref_q <= sysref_i;
			state_q <= state_d;
			ilas_cnt_q <= ilas_cnt_d;
			sync_dly_q <= osc_sync;
			osc_valid_q <= osc_valid_d;
			pin_q <= pin_d;
			cgs_q <= (state_d == amnu_pkg::LNK_CGS);
			ilas_q <= (state_d == amnu_pkg::LNK_ILAS);
			data_q <= (state_d == amnu_pkg::LNK_DATA);
		end
	end

	assign alarm_o = summary;
	assign cal_state_pin_o = pin_q;
	assign link_rst_o = !link_en;
	assign ser_pd_o = !link_en;
	assign link_clk_en_o = link_en;
	assign lmfc_edge_o = lmfc_edge;
	assign tx_cgs_o = cgs_q;
	assign tx_ilas_o = ilas_q;
	assign tx_data_o = data_q;

endmodule // amnu_top

// file: tb/amnu_chk.sv
// Port-level assertions for the alarm monitor.
`timescale 1ns/1ps
module amnu_chk (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	// Status and link
	input wire logic sysref_i,
	input wire logic sync_n_i,
	input wire logic cal_busy_i,
	input wire logic alarm_o,
	input wire logic cal_state_pin_o,
	input wire logic link_rst_o,
	input wire logic ser_pd_o,
	input wire logic link_clk_en_o,
	input wire logic lmfc_edge_o,
	input wire logic tx_cgs_o,
	input wire logic tx_ilas_o,
	input wire logic tx_data_o
);
	// ------------------------------------------------------------
	// Frame edge spacing, skipped for two edges after a capture
	// ------------------------------------------------------------
	logic [7:0] gap_q, gap_d;
	logic [1:0] dis_q, dis_d;
	always_comb begin
		gap_d = lmfc_edge_o ? 8'h00 : gap_q + 8'h01;
		dis_d = (lmfc_edge_o && dis_q != 2'h0) ? dis_q - 2'h1 : dis_q;
		if (rst_i || sysref_i) begin
			dis_d = 2'h2;
		end
	end
	always_ff @(posedge clk_i) begin
		gap_q <= gap_d;
		dis_q <= dis_d;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	link_gate_a: assert property (link_rst_o == ser_pd_o && link_clk_en_o == !link_rst_o)
		else $error("link gating mismatch");
	off_state_a: assert property (link_rst_o |=> !(tx_cgs_o || tx_ilas_o || tx_data_o))
		else $error("link active while disabled");
	state_hot_a: assert property ($onehot0({tx_cgs_o, tx_ilas_o, tx_data_o})) else $error("link state not one-hot");
	start_cgs_a: assert property ($fell(link_rst_o) |=> tx_cgs_o) else $error("enable did not start cgs");
	ilas_entry_a: assert property ($rose(tx_ilas_o) |-> $past(tx_cgs_o) && $past(sync_n_i))
		else $error("ilas entered wrongly");
	resync_cgs_a: assert property (!sync_n_i && (tx_ilas_o || tx_data_o) && !link_rst_o |=> tx_cgs_o)
		else $error("sync request ignored");
	frame_period_a: assert property (lmfc_edge_o && dis_q == 2'h0 |-> gap_q == 8'd31)
		else $error("frame edge spacing wrong");
	pin_cause_a: assert property ($rose(cal_state_pin_o) |-> $past(alarm_o) || $past(cal_busy_i))
		else $error("pin rose without cause");
	alarm_sticky_a: assert property ($fell(alarm_o) |-> $past(wb_ack_o && wb_we_i))
		else $error("alarm fell without write");
endmodule // amnu_chk

bind amnu_top amnu_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .sysref_i(sysref_i), .sync_n_i(sync_n_i), .cal_busy_i(cal_busy_i),
	.alarm_o(alarm_o), .cal_state_pin_o(cal_state_pin_o), .link_rst_o(link_rst_o), .ser_pd_o(ser_pd_o),
	.link_clk_en_o(link_clk_en_o), .lmfc_edge_o(lmfc_edge_o), .tx_cgs_o(tx_cgs_o), .tx_ilas_o(tx_ilas_o),
	.tx_data_o(tx_data_o));

// file: tb/amnu_rx_model.sv
// Link receiver model driving the active-low sync request.
`timescale 1ns/1ps
module amnu_rx_model #(
	parameter int unsigned CGS_WAIT = 5,
	parameter int unsigned RBD = 0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link state and bench commands
	input wire logic tx_cgs_i,
	input wire logic hold_i,
	input wire logic resync_i,
	input wire logic tx_data_i,
	input wire logic lmfc_i,
	// Sync request and buffer release
	output logic sync_n_o,
	output logic release_o
);
	logic [7:0] cnt_q;
	logic [7:0] since_q;
	logic [7:0] offset;

	// Frame clocks counted from the last frame edge; the release point sits RBD clocks after it.
	assign offset = lmfc_i ? 8'h00 : since_q;

	// Buffers release only at a release point once data arrives; RBD must avoid the arrival spread.
	always_ff @(posedge clk_i) begin
		since_q <= offset + 8'h01;
		if (rst_i || !tx_data_i) begin
			release_o <= 1'b0;
		end else if (offset == 8'(RBD)) begin
			release_o <= 1'b1;
		end
	end

	// The request is held low until code groups have been seen for a while; the count pauses while hold_i is high.
	always_ff @(posedge clk_i) begin
		if (rst_i || resync_i) begin
			sync_n_o <= 1'b0;
			cnt_q <= 8'h00;
		end else if (tx_cgs_i && !sync_n_o && !hold_i) begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == 8'(CGS_WAIT)) begin
				sync_n_o <= 1'b1;
			end
		end
	end
endmodule // amnu_rx_model

// file: tb/tb_amnu_top.sv
// Self-checking bench for the alarm monitor with a receiver model on the link.
`timescale 1ns/1ps
module tb_amnu_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [31:0] osc_a, osc_b;
	logic rel;
	logic fifo_err = 1'b0, pll_ok = 1'b1, upset = 1'b0, busy = 1'b0, sysref = 1'b0, hold = 1'b1, resync = 1'b0;
	logic [1:0] sel_a = 2'h1, sel_b = 2'h2;
	logic wb_ack_o, sync_n, alarm_o, pin, link_rst_o, ser_pd_o, clk_en_o, lmfc, cgs, ilas, data, prev;
	logic [5:0] m;
	logic [31:0] rnd = 32'h6d16535e;
	int errors = 0, num_checks = 0, n;
	int src[4] = '{0, 1, 3, 5};

	amnu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ser_fifo_err_i(fifo_err), .ser_pll_locked_i(pll_ok), .clk_upset_i(upset),
		.cal_busy_i(busy), .sysref_i(sysref), .sync_n_i(sync_n), .chan_a_osc_select_pins_i(sel_a),
		.chan_b_osc_select_pins_i(sel_b), .alarm_o(alarm_o), .cal_state_pin_o(pin), .link_rst_o(link_rst_o),
		.ser_pd_o(ser_pd_o), .link_clk_en_o(clk_en_o), .lmfc_edge_o(lmfc), .tx_cgs_o(cgs), .tx_ilas_o(ilas),
		.tx_data_o(data), .chan_a_osc_o(osc_a), .chan_b_osc_o(osc_b));
	amnu_rx_model #(.CGS_WAIT(5)) u_rx (.clk_i(clk_i), .rst_i(rst_i), .tx_cgs_i(cgs), .hold_i(hold),
		.resync_i(resync), .tx_data_i(data), .lmfc_i(lmfc), .sync_n_o(sync_n), .release_o(rel));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic exp_alarm(input logic [5:0] f, input logic [5:0] mk);
		return |(f & ~mk);
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge clk_i);
		n++;
		if (n > 800) begin
			errors++;
			$display("wrong value wait expected done seen timeout");
			report_and_stop();
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do tick(); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		tick();
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check($sformatf("reg %h", adr), q, exp);
	endtask
	task automatic fire(input int i);
		n = 0;
		if (i == 3) while (lmfc !== 1'b1) tick();
		case (i)
			0: fifo_err <= 1'b1;
			1: pll_ok <= 1'b0;
			3: sysref <= 1'b1;
			default: upset <= 1'b1;
		endcase
		@(posedge clk_i);
		{fifo_err, pll_ok, sysref, upset} <= 4'h4;
		@(posedge clk_i);
	endtask
	task automatic wait_data();
		n = 0;
		while (data !== 1'b1) tick();
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		sel_a <= rnd[1:0];
		sel_b <= rnd[3:2];
		@(posedge clk_i);
		check("link_rst", link_rst_o, 1);
		rd_chk(amnu_pkg::ADR_CTRL, 0);
		rd_chk(amnu_pkg::ADR_MASK, 0);
		rd_chk(amnu_pkg::ADR_STATUS, 0);
		rd_chk(amnu_pkg::ADR_TIMING, 32'h00042020);
		wb(1'b1, 8'h24, 32'hffffffff);
		rd_chk(8'h24, 0);
		wb(1'b1, amnu_pkg::ADR_PHASE_A + {4'h0, sel_a, 2'b00}, 32'h2468ace1);
		wb(1'b1, amnu_pkg::ADR_PHASE_B + {4'h0, sel_a, 2'b00}, 32'h2468ace1);
		@(posedge clk_i);
		check("osc_a", osc_a, 32'h2468ace1);
		check("osc_b", osc_b, (sel_b == sel_a) ? 32'h2468ace1 : 32'h0);
		wb(1'b1, amnu_pkg::ADR_CTRL, 32'h8);
		foreach (src[k]) begin
			fire(src[k]);
			m = 6'h01 << src[k];
			rd_chk(amnu_pkg::ADR_STATUS, m);
			rnd = lfsr(rnd);
			wb(1'b1, amnu_pkg::ADR_STATUS, rnd[5:0] & ~m);
			rd_chk(amnu_pkg::ADR_STATUS, m);
			wb(1'b1, amnu_pkg::ADR_MASK, rnd[13:8]);
			check("alarm", alarm_o, exp_alarm(m, rnd[13:8]));
			@(posedge clk_i);
			check("pin", pin, exp_alarm(m, rnd[13:8]));
			wb(1'b1, amnu_pkg::ADR_MASK, 0);
			wb(1'b1, amnu_pkg::ADR_STATUS, m);
			rd_chk(amnu_pkg::ADR_STATUS, 0);
		end
		wb(1'b1, amnu_pkg::ADR_CTRL, 0);
		prev = 1'b0;
		repeat (12) begin
			@(posedge clk_i);
			check("pin", pin, prev);
			prev = busy;
			rnd = lfsr(rnd);
			busy <= rnd[0];
		end
		busy <= 1'b0;
		wb(1'b1, amnu_pkg::ADR_CTRL, 32'h19);
		repeat (40) @(posedge clk_i);
		check("cgs", cgs, 1);
		rd_chk(amnu_pkg::ADR_STATUS, 32'h4);
		check("pin", pin, 1);
		hold <= 1'b0;
		wait_data();
		n = 0;
		while (rel !== 1'b1) tick();
		check("release wait", n <= 33, 1);
		rd_chk(amnu_pkg::ADR_SUMMARY, 32'h33);
		wb(1'b1, amnu_pkg::ADR_STATUS, 32'h3f);
		rd_chk(amnu_pkg::ADR_STATUS, 0);
		rnd = lfsr(rnd);
		wb(1'b1, amnu_pkg::ADR_FREQ_B, rnd | 32'h1);
		rd_chk(amnu_pkg::ADR_SUMMARY, 32'h30);
		rd_chk(amnu_pkg::ADR_STATUS, 0);
		resync <= 1'b1;
		@(posedge clk_i);
		resync <= 1'b0;
		n = 0;
		do tick(); while (cgs !== 1'b1);
		wait_data();
		rd_chk(amnu_pkg::ADR_STATUS, 32'h14);
		wb(1'b1, amnu_pkg::ADR_CTRL, 0);
		check("link_rst", link_rst_o, 1);
		@(posedge clk_i);
		check("state", {cgs, ilas, data}, 0);
		wb(1'b1, amnu_pkg::ADR_CTRL, 32'h71);
		prev = 1'b0;
		n = 0;
		while (data !== 1'b1) begin
			tick();
			prev = prev | ilas;
		end
		check("ilas", prev, 0);
		wb(1'b1, amnu_pkg::ADR_STATUS, 32'h3f);
		fire(3);
		rd_chk(amnu_pkg::ADR_STATUS, 0);
		report_and_stop();
	end
endmodule // tb_amnu_top
